// ==== hw/pack_protect_fet_wake_ctrl.sv ====
// Pack protection controller: FET gates, load release, bias, wake, serial
module pack_protect_fet_wake_ctrl
    import pack_prot_pkg::*;
#(
    parameter logic [6:0] I2C_ADDR      = I2C_ADDR_DEFAULT,
    parameter int         OC_DELAY_UNIT = OC_DELAY_UNIT_CYC,
    parameter int         SC_DELAY_UNIT = SC_DELAY_UNIT_CYC
) (
    input  wire logic                   clk,                  // 10 MHz clock
    input  wire logic                   rst,                  // Async reset
    input  wire logic                   scl_in,               // Serial clock
    input  wire logic                   sda_in,               // Data line
    output logic                        sda_out,              // Data drive
    output logic                        sda_oe,               // Pull data low
    input  wire pack_prot_pkg::det_t    det,                  // Comparators
    input  wire logic                   load_monitor_low,     // Load removed
    input  wire logic                   thermistor_sense_low, // Below 1/13
    input  wire logic                   wake_pin_level,       // Wake comp
    output logic                        discharge_gate_drive, // Dsg FET gate
    output logic                        charge_gate_drive,    // Chg FET gate
    output logic                        load_sense_en,        // Load resistor
    output logic [3:0]                  analog_mux_sel,       // Mux source
    output logic                        thermistor_bias_out,  // Bias switch
    output logic                        wake_event,           // Wake pulse
    output pack_prot_pkg::thresh_t      thresholds,           // To comps
    output pack_prot_pkg::delay_t       delays,               // Delay codes
    output pack_prot_pkg::status_t      status                // Flag levels
);
    import pack_prot_pkg::*;

    // Serial target state
    i2c_state_t state_q;
    i2c_state_t next_q;
    logic       scl_q;
    logic       sda_q;
    logic [7:0] shift_q;
    logic [3:0] bit_cnt_q;
    logic [2:0] ptr_q;
    logic       nack_q;
    logic       wr_en_q;
    logic [7:0] wr_data_q;
    logic [2:0] wr_ptr_q;
    logic [7:0] rd_data;

    // Register state
    ctrl_t      ctrl_q;
    logic [3:0] mux_q;
    thresh_t    thresh_q;
    delay_t     delay_q;
    logic       dsc_q;
    logic       doc_q;
    logic       coc_q;
    logic       load_fault_q;

    // Fault qualification
    logic [DELAY_W-1:0] limit [3];
    logic [2:0]         trips;
    logic [2:0]         raw;
    logic               dsc_trip;
    logic               doc_trip;
    logic               coc_trip;
    logic               wake_level;
    logic               wake_pulse;

    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;

    assign scl_rise = scl_in & ~scl_q;
    assign scl_fall = ~scl_in & scl_q;
    assign start_c  = scl_in & scl_q & sda_q & ~sda_in;
    assign stop_c   = scl_in & scl_q & ~sda_q & sda_in;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_in;
            sda_q <= sda_in;
        end
    end

    // Open-drain: only ever pulls low
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
        end
    end

    always_comb begin
        unique case (ptr_q)
            REG_CTRL[2:0]:   rd_data = 8'(ctrl_q);
            REG_MUX[2:0]:    rd_data = 8'(mux_q);
            REG_THRESH[2:0]: rd_data = 8'(thresh_q);
            REG_DELAY[2:0]:  rd_data = 8'(delay_q);
            REG_STATUS[2:0]: rd_data = 8'(status);
            default:         rd_data = 8'h00;
        endcase
    end

    // Byte framing; clock taken as input only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q   <= ST_IDLE;
            next_q    <= ST_IDLE;
            shift_q   <= 8'h00;
            bit_cnt_q <= 4'h0;
            ptr_q     <= PTR_RST;
            nack_q    <= 1'b0;
            sda_oe    <= 1'b0;
            wr_en_q   <= 1'b0;
            wr_data_q <= 8'h00;
            wr_ptr_q  <= PTR_RST;
        end else begin
            wr_en_q <= 1'b0;
            if (start_c) begin
                state_q   <= ST_ADDR;
                bit_cnt_q <= 4'h0;
                sda_oe    <= 1'b0;
            end else if (stop_c) begin
                state_q <= ST_IDLE;
                sda_oe  <= 1'b0;
            end else begin
                unique case (state_q)
                    ST_IDLE: begin
                        sda_oe <= 1'b0;
                    end
                    ST_ADDR, ST_REG, ST_WR: begin
                        if (scl_rise && bit_cnt_q != 4'h8) begin
                            shift_q   <= {shift_q[6:0], sda_in};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end else if (scl_fall && bit_cnt_q == 4'h8) begin
                            bit_cnt_q <= 4'h0;
                            sda_oe    <= 1'b1;
                            state_q   <= ST_ACK;
                            if (state_q == ST_ADDR) begin
                                if (shift_q[7:1] != I2C_ADDR) begin
                                    sda_oe  <= 1'b0;
                                    state_q <= ST_IDLE;
                                end
                                next_q <= shift_q[0] ? ST_RD : ST_REG;
                            end else if (state_q == ST_REG) begin
                                ptr_q  <= shift_q[2:0];
                                next_q <= ST_WR;
                            end else begin
                                wr_en_q   <= 1'b1;
                                wr_data_q <= shift_q;
                                wr_ptr_q  <= ptr_q;
                                ptr_q     <= ptr_q + 3'h1;
                                next_q    <= ST_WR;
                            end
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            state_q   <= next_q;
                            bit_cnt_q <= 4'h0;
                            sda_oe    <= 1'b0;
                            if (next_q == ST_RD) begin
                                shift_q <= rd_data;
                                sda_oe  <= ~rd_data[7];
                                ptr_q   <= ptr_q + 3'h1;
                            end
                        end
                    end
                    ST_RD: begin
                        if (scl_fall) begin
                            if (bit_cnt_q == 4'h7) begin
                                sda_oe  <= 1'b0;
                                state_q <= ST_RACK;
                            end else begin
                                shift_q   <= {shift_q[6:0], 1'b0};
                                sda_oe    <= ~shift_q[6];
                                bit_cnt_q <= bit_cnt_q + 4'h1;
                            end
                        end
                    end
                    ST_RACK: begin
                        if (scl_rise) begin
                            nack_q <= sda_in;
                        end else if (scl_fall) begin
                            bit_cnt_q <= 4'h0;
                            if (nack_q) begin
                                state_q <= ST_IDLE;
                            end else begin
                                state_q <= ST_RD;
                                shift_q <= rd_data;
                                sda_oe  <= ~rd_data[7];
                                ptr_q   <= ptr_q + 3'h1;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // Configuration registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mux_q    <= MUX_RST;
            thresh_q <= THRESH_RST;
            delay_q  <= DELAY_RST;
        end else if (wr_en_q) begin
            if (wr_ptr_q == REG_MUX[2:0]) begin
                mux_q <= wr_data_q[3:0];
            end
            if (wr_ptr_q == REG_THRESH[2:0]) begin
                thresh_q <= thresh_t'(wr_data_q[5:0]);
            end
            if (wr_ptr_q == REG_DELAY[2:0]) begin
                delay_q <= delay_t'(wr_data_q[6:0]);
            end
        end
    end

    // Control bits; a trip overrides a same-cycle turn-on
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= CTRL_RST;
        end else begin
            if (wr_en_q && wr_ptr_q == REG_CTRL[2:0]) begin
                ctrl_q <= ctrl_t'(wr_data_q[4:0]);
            end
            if (dsc_trip || doc_trip) begin
                ctrl_q.discharge_on <= 1'b0;
            end
            if (coc_trip) begin
                ctrl_q.charge_on <= 1'b0;
            end
        end
    end

    // Detection delays per channel: dsc, doc, coc
    always_comb begin
        limit[0] = DELAY_W'(SC_DELAY_UNIT) << delay_q.sc;
        limit[1] = DELAY_W'(OC_DELAY_UNIT) << delay_q.discharge_overcurrent_flag;
        limit[2] = DELAY_W'(OC_DELAY_UNIT) << delay_q.charge_overcurrent_flag;
    end

    assign raw      = {det.charge_overcurrent_flag, det.discharge_overcurrent_flag, det.discharge_short_flag};
    assign dsc_trip = trips[0];
    assign doc_trip = trips[1];
    assign coc_trip = trips[2];

    for (genvar i = 0; i < 3; i++) begin : g_trip
        trip_filter #(
            .W(DELAY_W)
        ) u_trip (
            .clk   (clk),
            .rst   (rst),
            .det   (raw[i]),
            .limit (limit[i]),
            .trip  (trips[i])
        );
    end

    // Sticky fault flags, write one to clear, set wins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dsc_q <= 1'b0;
            doc_q <= 1'b0;
            coc_q <= 1'b0;
        end else begin
            if (wr_en_q && wr_ptr_q == REG_STATUS[2:0]) begin
                dsc_q <= dsc_q & ~wr_data_q[0];
                doc_q <= doc_q & ~wr_data_q[1];
                coc_q <= coc_q & ~wr_data_q[2];
            end
            if (dsc_trip) begin
                dsc_q <= 1'b1;
            end
            if (doc_trip) begin
                doc_q <= 1'b1;
            end
            if (coc_trip) begin
                coc_q <= 1'b1;
            end
        end
    end

    // Load fault: set by discharge trip, released when the load goes away while load_mon_en is set
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            load_fault_q <= 1'b0;
        end else if (dsc_trip || doc_trip) begin
            load_fault_q <= 1'b1;
        end else if (ctrl_q.load_mon_en && load_monitor_low) begin
            load_fault_q <= 1'b0;
        end
    end

    wake_detect u_wake (
        .clk        (clk),
        .rst        (rst),
        .pin_level  (wake_pin_level),
        .wake_pol   (ctrl_q.wake_pol),
        .level_bit  (wake_level),
        .wake_pulse (wake_pulse)
    );

    // Pin-facing outputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            discharge_gate_drive <= 1'b0;
            charge_gate_drive    <= 1'b0;
            load_sense_en        <= 1'b0;
            analog_mux_sel       <= MUX_RST;
            thermistor_bias_out  <= 1'b0;
            wake_event           <= 1'b0;
            thresholds           <= THRESH_RST;
            delays               <= DELAY_RST;
        end else begin
            discharge_gate_drive <= ctrl_q.discharge_on
                                    & ~dsc_trip & ~doc_trip;
            charge_gate_drive    <= ctrl_q.charge_on & ~coc_trip;
            load_sense_en        <= ctrl_q.load_mon_en;
            analog_mux_sel       <= mux_q;
            thermistor_bias_out  <= (mux_q == MUX_EXT_TEMP)
                                    | ctrl_q.bias_force
                                    | dsc_q | doc_q | coc_q;
            wake_event           <= wake_pulse;
            thresholds           <= thresh_q;
            delays               <= delay_q;
        end
    end

    // Status levels; overtemp valid only while the divider is biased
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            status <= STATUS_RST;
        end else begin
            status.discharge_short_flag          <= dsc_q;
            status.discharge_overcurrent_flag          <= doc_q;
            status.charge_overcurrent_flag          <= coc_q;
            status.load_fault   <= load_fault_q;
            status.ext_overtemp <= thermistor_sense_low
                                   & thermistor_bias_out;
            status.wake_level   <= wake_level;
        end
    end

endmodule

// ==== hw/pack_prot_pkg.sv ====
// Shared constants and types for the pack protection controller
package pack_prot_pkg;

    localparam int CLK_FREQ_MHZ = 10;

    // Detection delay steps; a delay code doubles the step per increment
    localparam int OC_DELAY_UNIT_US  = 100;
    localparam int OC_DELAY_UNIT_CYC = OC_DELAY_UNIT_US * CLK_FREQ_MHZ;
    localparam int SC_DELAY_UNIT_US  = 10;
    localparam int SC_DELAY_UNIT_CYC = SC_DELAY_UNIT_US * CLK_FREQ_MHZ;
    localparam int DELAY_W           = 18;

    // Serial register map
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_MUX    = 8'h01;
    localparam logic [7:0] REG_THRESH = 8'h02;
    localparam logic [7:0] REG_DELAY  = 8'h03;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [2:0] PTR_RST    = 3'h0;

    // Arbitrary neutral target address
    localparam logic [6:0] I2C_ADDR_DEFAULT = 7'h28;

    // Mux code that routes the thermistor divider
    localparam logic [3:0] MUX_EXT_TEMP = 4'h8;
    localparam logic [3:0] MUX_RST      = 4'h0;

    typedef struct packed {
        logic wake_pol;
        logic bias_force;
        logic load_mon_en;
        logic charge_on;
        logic discharge_on;
    } ctrl_t;

    typedef struct packed {
        logic [1:0] charge_overcurrent_flag;
        logic [1:0] sc;
        logic [1:0] discharge_overcurrent_flag;
    } thresh_t;

    typedef struct packed {
        logic       sc;
        logic [2:0] charge_overcurrent_flag;
        logic [2:0] discharge_overcurrent_flag;
    } delay_t;

    typedef struct packed {
        logic charge_overcurrent_flag;
        logic discharge_overcurrent_flag;
        logic discharge_short_flag;
    } det_t;

    typedef struct packed {
        logic wake_level;
        logic ext_overtemp;
        logic load_fault;
        logic charge_overcurrent_flag;
        logic discharge_overcurrent_flag;
        logic discharge_short_flag;
    } status_t;

    localparam ctrl_t   CTRL_RST   = '0;
    localparam thresh_t THRESH_RST = '0;
    localparam delay_t  DELAY_RST  = '0;
    localparam status_t STATUS_RST = '0;

    typedef enum logic [6:0] {
        ST_IDLE = 7'b0000001,
        ST_ADDR = 7'b0000010,
        ST_REG  = 7'b0000100,
        ST_WR   = 7'b0001000,
        ST_ACK  = 7'b0010000,
        ST_RD   = 7'b0100000,
        ST_RACK = 7'b1000000
    } i2c_state_t;

endpackage

// ==== hw/trip_filter.sv ====
// Qualifies a fault comparator over a programmable detection delay
module trip_filter #(
    parameter int W = 18
) (
    input  wire logic         clk,   // System clock
    input  wire logic         rst,   // Async reset, active high
    input  wire logic         det,   // Raw comparator level
    input  wire logic [W-1:0] limit, // Cycles the level must persist
    output logic              trip   // One-cycle trip pulse
);
    logic [W-1:0] count_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_q <= '0;
        end else if (!det) begin
            count_q <= '0;
        end else if (count_q != limit) begin
            count_q <= count_q + 1'b1;
        end
    end

    // Fires once per persistent fault; counter saturates at the limit
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            trip <= 1'b0;
        end else begin
            trip <= det && (count_q == limit - 1'b1);
        end
    end
endmodule

// ==== hw/wake_detect.sv ====
// Wake level bit and polarity-selected wake edge
module wake_detect (
    input  wire logic clk,        // System clock
    input  wire logic rst,        // Async reset, active high
    input  wire logic pin_level,  // Wake comparator, high above threshold
    input  wire logic wake_pol,   // 1 rising wake, 0 falling wake
    output logic      level_bit,  // Level-sensitive wake status
    output logic      wake_pulse  // One-cycle wake event
);
    logic pol_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            level_bit <= 1'b0;
            pol_q     <= 1'b0;
        end else begin
            level_bit <= ~(pin_level ^ wake_pol);
            pol_q     <= wake_pol;
        end
    end

    // A polarity change alone must not look like an edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wake_pulse <= 1'b0;
        end else begin
            wake_pulse <= ~(pin_level ^ wake_pol) & ~level_bit
                          & (pol_q == wake_pol);
        end
    end
endmodule

// ==== dv/pack_prot_properties.sv ====
// Port-level assertions for the pack protection controller
module pack_prot_checker
    import pack_prot_pkg::*;
(
    input wire logic                 clk,                  // Clock
    input wire logic                 rst,                  // Reset
    input wire logic                 sda_out,              // Data drive
    input wire pack_prot_pkg::det_t  det,                  // Comparators
    input wire logic                 load_monitor_low,     // Load gone
    input wire logic                 thermistor_sense_low, // Sense low
    input wire logic                 wake_pin_level,       // Wake pin
    input wire logic                 discharge_gate_drive, // Dsg gate
    input wire logic                 charge_gate_drive,    // Chg gate
    input wire logic                 thermistor_bias_out,  // Bias
    input wire logic                 wake_event,           // Wake pulse
    input wire pack_prot_pkg::status_t status              // Flags
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_dsg_doc;
        $rose(status.discharge_overcurrent_flag) |-> !discharge_gate_drive;
    endproperty
    a_dsg_doc: assert property (p_dsg_doc)
        else $error("discharge gate on after overcurrent");
    property p_dsc_cause;
        $rose(status.discharge_short_flag) |-> $past(det.discharge_short_flag, 2) || $past(det.discharge_short_flag, 3);
    endproperty
    a_dsc_cause: assert property (p_dsc_cause)
        else $error("short flag without short");
    property p_chg_coc;
        $rose(status.charge_overcurrent_flag) |-> !charge_gate_drive;
    endproperty
    a_chg_coc: assert property (p_chg_coc)
        else $error("charge gate on after overcurrent");
    property p_bias_flag;
        (status.discharge_short_flag || status.discharge_overcurrent_flag || status.charge_overcurrent_flag) |-> thermistor_bias_out;
    endproperty
    a_bias_flag: assert property (p_bias_flag)
        else $error("bias off with fault flag");
    property p_overtemp;
        $rose(status.ext_overtemp) |->
            $past(thermistor_sense_low, 1) || $past(thermistor_sense_low, 2);
    endproperty
    a_overtemp: assert property (p_overtemp)
        else $error("overtemp without low sense");
    property p_wake_cause;
        wake_event |-> $past(wake_pin_level, 1) != $past(wake_pin_level, 5);
    endproperty
    a_wake_cause: assert property (p_wake_cause)
        else $error("wake without pin edge");
    property p_wake_pulse;
        wake_event |=> !wake_event;
    endproperty
    a_wake_pulse: assert property (p_wake_pulse)
        else $error("wake pulse too long");
    property p_load_clear;
        $fell(status.load_fault) |->
            $past(load_monitor_low, 2) || $past(load_monitor_low, 3);
    endproperty
    a_load_clear: assert property (p_load_clear)
        else $error("load fault cleared with load present");
    property p_open_drain;
        !sda_out;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("data line driven high");
endmodule

bind pack_protect_fet_wake_ctrl pack_prot_checker u_chk (
    .clk, .rst, .sda_out, .det, .load_monitor_low, .thermistor_sense_low,
    .wake_pin_level, .discharge_gate_drive, .charge_gate_drive,
    .thermistor_bias_out, .wake_event, .status
);

// ==== dv/pack_host_model.sv ====
// Serial host model standing in for the pack microcontroller
module pack_host_model
    import pack_prot_pkg::*;
#(
    parameter logic [6:0] ADDR = I2C_ADDR_DEFAULT // Target address
) (
    input  wire logic clk,      // Bench clock
    input  wire logic sda_line, // Resolved data line
    output logic      scl,      // Serial clock, host only
    output logic      sda       // 1 releases line to pull-up
);
    localparam int PH = 4;
    logic ack;

    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end

    task automatic hold();
        repeat (PH) @(posedge clk);
    endtask

    task automatic bit_io(input logic b, output logic r);
        scl <= 1'b0;
        hold();
        sda <= b;
        hold();
        scl <= 1'b1;
        hold();
        r = sda_line;
    endtask

    task automatic start_c();
        @(posedge clk);
        scl <= 1'b0;
        hold();
        sda <= 1'b1;
        hold();
        scl <= 1'b1;
        hold();
        sda <= 1'b0;
        hold();
    endtask

    task automatic stop_c();
        scl <= 1'b0;
        hold();
        sda <= 1'b0;
        hold();
        scl <= 1'b1;
        hold();
        sda <= 1'b1;
        hold();
    endtask

    task automatic tx(input logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask

    task automatic wr(input logic [7:0] p, input logic [7:0] d,
                      output logic ok);
        start_c();
        tx({ADDR, 1'b0});
        ok = ack;
        tx(p);
        ok &= ack;
        tx(d);
        ok &= ack;
        stop_c();
    endtask

    task automatic rd(input logic [7:0] p, output logic [7:0] d,
                      output logic ok);
        logic r;
        start_c();
        tx({ADDR, 1'b0});
        ok = ack;
        tx(p);
        ok &= ack;
        start_c();
        tx({ADDR, 1'b1});
        ok &= ack;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(1'b1, r);
        stop_c();
    endtask
endmodule

// ==== dv/tb_pack_protect_fet_wake_ctrl.sv ====
// Self-checking bench for the pack protection controller
module tb_pack_protect_fet_wake_ctrl;
    timeunit 1ns;
    timeprecision 1ns;
    import pack_prot_pkg::*;

    logic       clk;
    logic       rst;
    logic       scl;
    logic       host_sda;
    logic       sda_line;
    logic       sda_out;
    logic       sda_oe;
    det_t       det;
    logic       load_low;
    logic       sense_low;
    logic       wake_pin;
    logic       dsg;
    logic       chg;
    logic       load_en;
    logic [3:0] mux;
    logic       bias;
    logic       wake_ev;
    thresh_t    thr;
    delay_t     dly;
    status_t    st;
    int         bad_count;
    int         checked;

    assign sda_line = host_sda & ~(sda_oe & ~sda_out);

    pack_protect_fet_wake_ctrl #(.OC_DELAY_UNIT(4), .SC_DELAY_UNIT(2)) dut_u (
        .clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .det(det),
        .load_monitor_low(load_low), .thermistor_sense_low(sense_low),
        .wake_pin_level(wake_pin), .discharge_gate_drive(dsg),
        .charge_gate_drive(chg), .load_sense_en(load_en),
        .analog_mux_sel(mux), .thermistor_bias_out(bias),
        .wake_event(wake_ev), .thresholds(thr), .delays(dly), .status(st)
    );

    pack_host_model u_host (
        .clk(clk), .sda_line(sda_line), .scl(scl), .sda(host_sda)
    );

    always #50 clk = ~clk;

    task automatic chk(input logic ok, input string m);
        checked++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask

    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        logic ok;
        u_host.wr(p, d, ok);
        @(negedge clk);
        chk(ok, "write not acknowledged");
    endtask

    task automatic end_sim();
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic t_gates();
        chk(dsg === 1'b0 && chg === 1'b0, "gates on without command");
        wr(REG_CTRL, 8'h03);
        chk(dsg === 1'b1 && chg === 1'b1, "gates not on");
        wr(REG_CTRL, 8'h02);
        chk(dsg === 1'b0 && chg === 1'b1, "discharge not off");
        wr(REG_CTRL, 8'h00);
        chk(chg === 1'b0, "charge not off");
    endtask

    task automatic t_trips();
        for (int i = 0; i < 3; i++) begin
            wr(REG_CTRL, 8'h03);
            @(posedge clk);
            det <= det_t'(3'b001 << i);
            repeat (3) @(negedge clk);
            chk(dsg === 1'b1 && chg === 1'b1, "tripped early");
            repeat (8) @(negedge clk);
            chk(dsg === (i == 2), "discharge state");
            chk(chg === (i != 2), "charge state");
            chk(st[2:0] === 3'(det) && bias === 1'b1, "flag or bias");
            chk(st.load_fault === (i != 2), "load fault set");
            @(posedge clk);
            det <= '0;
            if (i != 2) begin
                wr(REG_CTRL, 8'h04);
                chk(load_en === 1'b1, "load sense off");
                chk(st.load_fault === 1'b1, "load fault lost");
                @(posedge clk);
                load_low <= 1'b1;
                repeat (5) @(negedge clk);
                chk(st.load_fault === 1'b0, "load fault kept");
                @(posedge clk);
                load_low <= 1'b0;
            end
            wr(REG_STATUS, 8'h07);
            chk(bias === 1'b0 && st[2:0] === 3'h0, "flags kept");
        end
    endtask

    task automatic t_mux_bias();
        logic [7:0] d;
        logic       ok;
        for (int m = 0; m < 16; m++) begin
            wr(REG_MUX, 8'(m));
            chk(mux === 4'(m), "mux select");
            chk(bias === (m == 8), "bias vs measurement");
        end
        u_host.rd(REG_MUX, d, ok);
        @(negedge clk);
        chk(ok === 1'b1 && d === 8'h0f, "mux readback");
        wr(REG_CTRL, 8'h08);
        chk(bias === 1'b1, "bias not forced");
        @(posedge clk);
        sense_low <= 1'b1;
        repeat (4) @(negedge clk);
        chk(st.ext_overtemp === 1'b1, "no overtemp");
        @(posedge clk);
        sense_low <= 1'b0;
        wr(REG_CTRL, 8'h00);
        chk(bias === 1'b0 && st.ext_overtemp === 1'b0, "bias kept");
    endtask

    task automatic t_wake();
        int n;
        for (int p = 0; p < 2; p++) begin
            wr(REG_CTRL, {3'h0, p[0], 4'h0});
            @(posedge clk);
            wake_pin <= ~p[0];
            for (int e = 0; e < 2; e++) begin
                repeat (6) @(posedge clk);
                n = 0;
                wake_pin <= ~wake_pin;
                repeat (6) begin
                    @(negedge clk);
                    if (wake_ev === 1'b1) n++;
                end
                chk(n == (e == 0 ? 1 : 0), "wake edges");
                chk(st.wake_level === (e == 0), "wake level");
            end
        end
    endtask

    task automatic t_regs();
        wr(REG_THRESH, 8'h3f);
        chk(thr === 6'h3f, "thresholds");
        wr(REG_DELAY, 8'h7f);
        chk(dly === 7'h7f, "delays");
    endtask

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        det = '0;
        load_low = 1'b0;
        sense_low = 1'b0;
        wake_pin = 1'b1;
        bad_count = 0;
        checked = 0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(negedge clk);
        t_gates();
        t_trips();
        t_mux_bias();
        t_wake();
        t_regs();
        end_sim();
    end

    initial begin
        repeat (40000) @(posedge clk);
        bad_count++;
        $display("[ERR] %0t watchdog expired", $time);
        end_sim();
    end
endmodule
